// ---- inc/e1lc_pkg.sv ----
// Purpose: shared constants and types of the e1 line configuration bank
// Assumes: apb byte addresses, one 32-bit word per register, 8 live bits, except status with live bits up to 15
// Notes:   offsets are used by design and bench alike, field positions by the design only
package e1lc_pkg;

    //////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [11:0] OFF_MODE      = 12'h000;
    localparam logic [11:0] OFF_CODE      = 12'h004;
    localparam logic [11:0] OFF_LOS_DET   = 12'h008;
    localparam logic [11:0] OFF_LOS_REC   = 12'h00c;
    localparam logic [11:0] OFF_CLK_CFG   = 12'h010;
    localparam logic [11:0] OFF_EXT_CLK   = 12'h014;
    localparam logic [11:0] OFF_PORT_CFG  = 12'h018;
    localparam logic [11:0] OFF_CMD       = 12'h01c;
    localparam logic [11:0] OFF_CNT_LATCH = 12'h020;
    localparam logic [11:0] OFF_STATUS    = 12'h024;
    localparam logic [5:0]  TXG_PAGE      = 6'h01;   // 0x040..0x07c

    //////////////////////////////////////////////////////////////////////
    // field positions
    localparam int MODE_STD       = 0;
    localparam int MODE_AIS_DIS   = 1;
    localparam int MODE_RX_FREE   = 2;
    localparam int MODE_TX_TRANSP = 3;
    localparam int MODE_TX_FREE   = 4;
    localparam int MODE_DIG_RAIL  = 5;
    localparam int MODE_CMI       = 6;
    localparam int CODE_TX_LSB    = 0;
    localparam int CODE_RX_LSB    = 2;
    localparam int CMD_TX_RES     = 0;
    localparam int CMD_RX_RES     = 1;
    localparam int STAT_LOS       = 0;
    localparam int STAT_SETTLING  = 1;
    localparam int STAT_T1        = 2;
    localparam int STAT_CNT_LSB   = 8;

    //////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_MODE     = 8'h00;
    localparam logic [7:0] RST_CODE     = 8'h00;
    localparam logic [7:0] RST_LOS_DET  = 8'h00;
    localparam logic [7:0] RST_LOS_REC  = 8'h00;
    localparam logic [7:0] RST_CLK_CFG  = 8'h10;
    localparam logic [7:0] RST_EXT_CLK  = 8'h00;
    localparam logic [7:0] RST_PORT_CFG = 8'h00;
    localparam logic [7:0] RST_TXG      = 8'h00;

    //////////////////////////////////////////////////////////////////////
    // timing
    localparam int LOS_DET_STEP  = 16;     // zeros per detect count step
    localparam int T1_SETTLE_US  = 20;
    localparam int CLK_MHZ       = 250;
    localparam int T1_SETTLE_CYC = T1_SETTLE_US * CLK_MHZ;
    localparam int E1_BIT_DIV    = 122;    // 250 MHz / 2.048 MHz, rounded down

    typedef enum logic [1:0] {E1LC_AMI, E1LC_HDB3, E1LC_CMI, E1LC_CMI_HDB3} e1lc_code_t;
    typedef enum logic [1:0] {E1LC_ST_E1, E1LC_ST_SETTLE, E1LC_ST_T1} e1lc_std_t;

endpackage

// ---- design/e1lc_los_det.sv ----
// Purpose: loss-of-signal detect and recovery on the received bit stream
// Assumes: bit_en marks one received bit per pulse
// Notes:   detect after (det+1)*16 zeros, recover on rec+1 ones per interval
`timescale 1ns/1ns
module e1lc_los_det
    import e1lc_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clr,
    input  wire logic       bit_en,
    input  wire logic       bit_in,
    input  wire logic [7:0] det_count,
    input  wire logic [7:0] rec_count,
    output logic            los
);

    logic [8:0]  det_p1;
    logic [12:0] det_thr;
    logic [8:0]  rec_thr;
    logic [12:0] zero_run_r;
    logic [12:0] win_r;
    logic [8:0]  ones_r;
    logic [8:0]  ones_nxt;
    logic        los_r;

    // thresholds from the two count registers
    assign det_p1   = {1'b0, det_count} + 9'd1;
    assign det_thr  = 13'(det_p1 * LOS_DET_STEP);
    assign rec_thr  = {1'b0, rec_count} + 9'd1;
    assign ones_nxt = ones_r + {8'd0, bit_in};
    assign los      = los_r;

    //////////////////////////////////////////////////////////////////////
    // zero run while in sync, ones per window while lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_run_r <= '0;
            win_r      <= '0;
            ones_r     <= '0;
            los_r      <= 1'b0;
        end else if (clr) begin
            zero_run_r <= '0;
            win_r      <= '0;
            ones_r     <= '0;
            los_r      <= 1'b0;
        end else if (bit_en && !los_r) begin
            if (bit_in) begin
                zero_run_r <= '0;
            end else if (zero_run_r + 13'd1 == det_thr) begin
                los_r      <= 1'b1;
                zero_run_r <= '0;
                win_r      <= '0;
                ones_r     <= '0;
            end else begin
                zero_run_r <= zero_run_r + 13'd1;
            end
        end else if (bit_en) begin
            if (ones_nxt == rec_thr) begin
                los_r  <= 1'b0;
                win_r  <= '0;
                ones_r <= '0;
            end else if (win_r + 13'd1 == det_thr) begin
                win_r  <= '0;
                ones_r <= '0;
            end else begin
                win_r  <= win_r + 13'd1;
                ones_r <= ones_nxt;
            end
        end
    end

    a_los_declare: assert property (
        @(posedge pclk) disable iff (!presetn)
        (det_count == 8'h0a && bit_en && !bit_in && !los_r && !clr && zero_run_r == 13'd175) |=> los_r)
        else $error("los not declared after 176 zeros");

    a_los_recover: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rec_count == 8'h15 && bit_en && bit_in && los_r && !clr && ones_r == 9'd21) |=> !los_r)
        else $error("los not cleared after 22 ones");

endmodule

// ---- design/e1lc_line_cfg.sv ----
// Purpose: apb register bank and control of one e1 line interface channel
// Assumes: apb master, single 250 MHz clock, line bit strobes synchronous
// Notes:   zero wait state slave; read data is captured in the setup cycle
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ns
// Operation
// - unused addresses read meaningless data; writes avoided or zero
// - control registers read back, except tx group, command and latch
// - ais insert disable bit suppresses ais on the data stream
// - rx free run bit runs the receive elastic store free
// - tx transparent bit passes transmit data unchanged
// - tx free run bit runs the transmitter from internal timing
// - analog line offers ami/hdb3; digital adds cmi with optional precode
// - detect count 0a hex declares los after 176 zeros
// - recovery count 15 hex clears los after 22 ones per interval
// - e1 after reset; t1 mode active only after 20 us settling
module e1lc_line_cfg
    import e1lc_pkg::*;
#(
    parameter int SETTLE_CYC = T1_SETTLE_CYC
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        legacy_pinout_sel,
    input  wire logic        rx_bit_en,
    input  wire logic        rx_bit,
    input  wire logic        rx_slip_req,
    input  wire logic        tx_bit_en_ext,
    input  wire logic        tx_data,
    input  wire logic [3:0]  tx_slot,
    output logic             rx_data_out,
    output logic             rx_slip,
    output logic             los,
    output logic             tx_line_bit,
    output logic             tx_bit_strobe,
    output logic [7:0]       tx_pattern,
    output e1lc_code_t       tx_code,
    output e1lc_code_t       rx_code,
    output logic             t1_mode_active,
    output logic             settling,
    output logic [7:0]       master_clock_cfg,
    output logic [7:0]       ext_clock_mode,
    output logic [7:0]       global_port_cfg,
    output logic             tx_soft_reset,
    output logic             rx_soft_reset
);

    //////////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0]  mode_r;
    logic [7:0]  code_r;
    logic [7:0]  los_det_r;
    logic [7:0]  los_rec_r;
    logic [7:0]  clk_cfg_r;
    logic [7:0]  ext_clk_r;
    logic [7:0]  port_cfg_r;
    logic [7:0]  txg_r [16];
    logic [31:0] prdata_r;
    logic        tx_res_r;
    logic        rx_res_r;
    logic [7:0]  los_evt_cnt_r;
    logic [7:0]  los_latched_r;
    logic        los_d_r;
    e1lc_std_t   std_r;
    logic [12:0] settle_cnt_r;
    logic [6:0]  div_cnt_r;
    logic        div_tick;
    logic        tx_strobe;
    logic        tx_line_r;
    logic        rx_data_r;
    logic        rx_slip_r;
    logic [7:0]  tx_pat_r;
    e1lc_code_t  tx_code_r;
    e1lc_code_t  rx_code_r;
    logic        los_w;

    logic        wr_en;
    logic        rd_setup;
    logic [7:0]  wdat;
    logic        hit_mode;
    logic        hit_code;
    logic        hit_det;
    logic        hit_rec;
    logic        hit_clk;
    logic        hit_ext;
    logic        hit_port;
    logic        hit_cmd;
    logic        hit_latch;
    logic        hit_stat;
    logic        hit_txg;
    logic        hit_any;
    logic        los_rise;
    logic [31:0] status_w;
    logic [31:0] rd_mux;

    //////////////////////////////////////////////////////////////////////
    // line code selection, shared by transmit and receive
    function automatic e1lc_code_t code_decode(input logic [1:0] fld, input logic dig, input logic cmi);
        e1lc_code_t c;
        c = fld[0] ? E1LC_HDB3 : E1LC_AMI;
        // cmi only exists on the digital rails
        if (dig && cmi && fld[1]) begin
            c = fld[0] ? E1LC_CMI_HDB3 : E1LC_CMI;
        end
        return c;
    endfunction

    //////////////////////////////////////////////////////////////////////
    // apb decode
    assign wr_en     = psel & penable & pwrite;
    assign rd_setup  = psel & ~penable & ~pwrite;
    assign wdat      = pwdata[7:0];
    assign hit_mode  = paddr == OFF_MODE;
    assign hit_code  = paddr == OFF_CODE;
    assign hit_det   = paddr == OFF_LOS_DET;
    assign hit_rec   = paddr == OFF_LOS_REC;
    assign hit_clk   = paddr == OFF_CLK_CFG;
    assign hit_ext   = paddr == OFF_EXT_CLK;
    assign hit_port  = paddr == OFF_PORT_CFG;
    assign hit_cmd   = paddr == OFF_CMD;
    assign hit_latch = paddr == OFF_CNT_LATCH;
    assign hit_stat  = paddr == OFF_STATUS;
    assign hit_txg   = (paddr[11:6] == TXG_PAGE) && (paddr[1:0] == 2'b00);
    assign hit_any   = hit_mode | hit_code | hit_det | hit_rec | hit_clk | hit_ext
                     | hit_port | hit_cmd | hit_latch | hit_stat | hit_txg;
    assign pready    = 1'b1;   // every access completes in its first access cycle
    assign pslverr   = 1'b0;   // unused addresses are not errors

    // status word: live los, settling, standard, latched los count
    assign status_w = {16'h0000, los_latched_r, 5'h00,
                       t1_mode_active, settling, los_w};

    assign rd_mux = hit_mode ? {24'h00_0000, mode_r}     :
                    hit_code ? {24'h00_0000, code_r}     :
                    hit_det  ? {24'h00_0000, los_det_r}  :
                    hit_rec  ? {24'h00_0000, los_rec_r}  :
                    hit_clk  ? {24'h00_0000, clk_cfg_r}  :
                    hit_ext  ? {24'h00_0000, ext_clk_r}  :
                    hit_port ? {24'h00_0000, port_cfg_r} :
                    hit_stat ? status_w                  :
                    32'h0000_0000;

    //////////////////////////////////////////////////////////////////////
    // read data captured at setup, stable through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_r <= rd_mux;
        end
    end
    assign prdata = prdata_r;

    //////////////////////////////////////////////////////////////////////
    // read/write control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r     <= RST_MODE;
            code_r     <= RST_CODE;
            los_det_r  <= RST_LOS_DET;
            los_rec_r  <= RST_LOS_REC;
            clk_cfg_r  <= RST_CLK_CFG;
            ext_clk_r  <= RST_EXT_CLK;
            port_cfg_r <= RST_PORT_CFG;
        end else if (wr_en) begin
            if (hit_mode) mode_r <= wdat;
            if (hit_code) code_r <= wdat;
            if (hit_det)  los_det_r <= wdat;
            if (hit_rec)  los_rec_r <= wdat;
            if (hit_clk)  clk_cfg_r <= wdat;
            if (hit_ext && !legacy_pinout_sel)  ext_clk_r <= wdat;
            if (hit_port && !legacy_pinout_sel) port_cfg_r <= wdat;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // write-only transmit group, one generated register per slot
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_txg
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    txg_r[gi] <= RST_TXG;
                end else if (wr_en && hit_txg && paddr[5:2] == 4'(gi)) begin
                    txg_r[gi] <= wdat;
                end
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////
    // command pulses: soft resets last one cycle after the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_res_r <= 1'b0;
            rx_res_r <= 1'b0;
        end else begin
            tx_res_r <= wr_en & hit_cmd & pwdata[CMD_TX_RES];
            rx_res_r <= wr_en & hit_cmd & pwdata[CMD_RX_RES];
        end
    end
    assign tx_soft_reset = tx_res_r;
    assign rx_soft_reset = rx_res_r;

    //////////////////////////////////////////////////////////////////////
    // los detector
    e1lc_los_det u_los (
        .pclk      (pclk),
        .presetn   (presetn),
        .clr       (rx_res_r),
        .bit_en    (rx_bit_en),
        .bit_in    (rx_bit),
        .det_count (los_det_r),
        .rec_count (los_rec_r),
        .los       (los_w)
    );
    assign los      = los_w;
    assign los_rise = los_w & ~los_d_r;

    // los event counter; a latch command snapshots it and restarts it,
    // an event in that same cycle is counted into the fresh count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            los_d_r       <= 1'b0;
            los_evt_cnt_r <= 8'h00;
            los_latched_r <= 8'h00;
        end else begin
            los_d_r <= los_w;
            if (wr_en && hit_latch) begin
                los_latched_r <= los_evt_cnt_r;
                los_evt_cnt_r <= {7'h00, los_rise};
            end else if (los_rise && los_evt_cnt_r != 8'hff) begin
                los_evt_cnt_r <= los_evt_cnt_r + 8'h01;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // standard switch with settling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            std_r        <= E1LC_ST_E1;
            settle_cnt_r <= '0;
        end else if (!mode_r[MODE_STD]) begin
            std_r        <= E1LC_ST_E1;   // back to e1 at once
            settle_cnt_r <= '0;
        end else begin
            case (std_r)
                E1LC_ST_E1: begin
                    std_r        <= E1LC_ST_SETTLE;
                    settle_cnt_r <= '0;
                end
                E1LC_ST_SETTLE: begin
                    if (settle_cnt_r == 13'(SETTLE_CYC - 1)) begin
                        std_r <= E1LC_ST_T1;
                    end else begin
                        settle_cnt_r <= settle_cnt_r + 13'd1;
                    end
                end
                E1LC_ST_T1: std_r <= E1LC_ST_T1;
                default:    std_r <= E1LC_ST_E1;
            endcase
        end
    end
    assign t1_mode_active = std_r == E1LC_ST_T1;
    assign settling       = std_r == E1LC_ST_SETTLE;

    //////////////////////////////////////////////////////////////////////
    // free-run bit timing
    // integer divider: slight rate error traded for a single clock
    assign div_tick  = div_cnt_r == 7'(E1_BIT_DIV - 1);
    assign tx_strobe = mode_r[MODE_TX_FREE] ? div_tick : tx_bit_en_ext;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= '0;
        end else if (div_tick || tx_res_r) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + 7'd1;
        end
    end
    assign tx_bit_strobe = tx_strobe;

    //////////////////////////////////////////////////////////////////////
    // transparent transmit path
    // without transparency the line idles at all ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_line_r <= 1'b1;
            tx_pat_r  <= RST_TXG;
        end else if (tx_res_r) begin
            tx_line_r <= 1'b1;
            tx_pat_r  <= RST_TXG;
        end else begin
            tx_pat_r <= txg_r[tx_slot];
            if (tx_strobe) begin
                tx_line_r <= mode_r[MODE_TX_TRANSP] ? tx_data : 1'b1;
            end
        end
    end
    assign tx_line_bit = tx_line_r;
    assign tx_pattern  = tx_pat_r;

    //////////////////////////////////////////////////////////////////////
    // ais suppression, free-running store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_r <= 1'b1;
            rx_slip_r <= 1'b0;
        end else begin
            // free-running store never reports a slip
            rx_slip_r <= rx_slip_req & ~mode_r[MODE_RX_FREE];
            if (rx_bit_en) begin
                rx_data_r <= (los_w && !mode_r[MODE_AIS_DIS]) ? 1'b1 : rx_bit;
            end
        end
    end
    assign rx_data_out = rx_data_r;
    assign rx_slip     = rx_slip_r;

    //////////////////////////////////////////////////////////////////////
    // code selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_code_r <= E1LC_AMI;
            rx_code_r <= E1LC_AMI;
        end else begin
            tx_code_r <= code_decode(code_r[CODE_TX_LSB +: 2], mode_r[MODE_DIG_RAIL], mode_r[MODE_CMI]);
            rx_code_r <= code_decode(code_r[CODE_RX_LSB +: 2], mode_r[MODE_DIG_RAIL], mode_r[MODE_CMI]);
        end
    end
    assign tx_code          = tx_code_r;
    assign rx_code          = rx_code_r;
    assign master_clock_cfg = clk_cfg_r;
    assign ext_clock_mode   = ext_clk_r;
    assign global_port_cfg  = port_cfg_r;

    //////////////////////////////////////////////////////////////////////
    // checks
    a_unused_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd_setup && !hit_any) |=> prdata == 32'h0000_0000)
        else $error("unused address read not zero");

    a_wo_readzero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rd_setup && (hit_cmd || hit_latch || hit_txg)) |=> prdata == 32'h0000_0000)
        else $error("write-only register read back data");

    a_ais_suppress: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_bit_en && !rx_bit && mode_r[MODE_AIS_DIS]) |=> !rx_data_out)
        else $error("ais inserted while disabled");

    a_rx_freerun: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_r[MODE_RX_FREE] |=> !rx_slip)
        else $error("slip reported in free-running store");

    a_tx_transp: assert property (
        @(posedge pclk) disable iff (!presetn)
        (tx_strobe && !tx_res_r && mode_r[MODE_TX_TRANSP]) |=> tx_line_bit == $past(tx_data))
        else $error("transmit data not passed transparently");

    a_tx_freerun: assert property (
        @(posedge pclk) disable iff (!presetn)
        (mode_r[MODE_TX_FREE] && $past(mode_r[MODE_TX_FREE]) && tx_bit_strobe)
            |=> !tx_bit_strobe [*8])
        else $error("free-run strobe spacing wrong");

    a_code_analog: assert property (
        @(posedge pclk) disable iff (!presetn)
        !$past(mode_r[MODE_DIG_RAIL]) |-> (tx_code inside {E1LC_AMI, E1LC_HDB3}))
        else $error("cmi selected on analog line");

    a_settle_time: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(t1_mode_active) |-> $past(settle_cnt_r) == 13'(SETTLE_CYC - 1) && $past(settling))
        else $error("t1 active before settling time");

endmodule

// ---- bench/e1lc_host.sv ----
// Purpose: host model driving the apb register port
// Assumes: answer taken at the first rising edge with pready high
// Notes:   released address and data are inverted, so stale values never pass
`timescale 1ns/1ns
module e1lc_host (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    ////////////////////////////////////////////////////////////
    // one transfer, held until pready is seen at a rising edge
    // upper bits zero during the transfer, ones once released
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~{24'h00_0000, d}};
    endtask
endmodule

// ---- bench/tb_e1_line_config_sequence.sv ----
// Purpose: self-checking bench for the e1 line configuration bank
// Assumes: short settling count, line bits fed by hand every other clock
// Notes:   line checks sampled at the falling edge; register checks right after the transfer's rising edge
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("mismatch %0t %h %h", $time, a, b); end end
module tb_e1_line_config_sequence
    import e1lc_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, rx_bit_en = 0, rx_bit = 0;
    logic        rx_slip_req = 0, tx_bit_en_ext = 0, tx_data = 0, legacy_pinout_sel = 0, rx_data_out, rx_slip;
    logic        los, tx_line_bit, tx_bit_strobe, t1_mode_active, settling, tx_soft_reset, rx_soft_reset;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  tx_slot = '0;
    logic [7:0]  tx_pattern, master_clock_cfg, ext_clock_mode, global_port_cfg;
    e1lc_code_t  tx_code, rx_code;
    int          fail_count = 0, num_checks = 0, cyc = 0, n;

    e1lc_line_cfg #(.SETTLE_CYC(20)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .legacy_pinout_sel, .rx_bit_en, .rx_bit, .rx_slip_req, .tx_bit_en_ext,
        .tx_data, .tx_slot, .rx_data_out, .rx_slip, .los, .tx_line_bit, .tx_bit_strobe, .tx_pattern, .tx_code,
        .rx_code, .t1_mode_active, .settling, .master_clock_cfg, .ext_clock_mode, .global_port_cfg,
        .tx_soft_reset, .rx_soft_reset);
    e1lc_host i_host (.pclk, .prdata, .pready, .psel, .penable, .pwrite, .paddr, .pwdata);

    ////////////////////////////////////////////////////////////
    // clock and hang guard, run needs about 1300 cycles
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (fail_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        i_host.xfer(1'b0, a, 8'h00, q);
        `CHK(q, {24'h00_0000, e})
    endtask
    // one received bit, strobe high for a single clock
    task automatic rxb(input logic b);
        @(posedge pclk);
        {rx_bit_en, rx_bit} <= {1'b1, b};
        @(posedge pclk);
        rx_bit_en <= 1'b0;
        @(negedge pclk);
    endtask
    // strobes over two divider periods
    task automatic cnt();
        n = 0;
        repeat (244) begin
            @(negedge pclk);
            n += int'(tx_bit_strobe);
        end
    endtask

    ////////////////////////////////////////////////////////////
    // legacy pinout low through reset
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_MODE, 8'h00);
        `CHK(master_clock_cfg, RST_CLK_CFG)
        // setup before activation, standard bit low
        wr(OFF_CLK_CFG, 8'h23);
        wr(OFF_MODE, 8'h1e);
        rd(OFF_MODE, 8'h1e);
        `CHK(master_clock_cfg, 8'h23)
        wr(OFF_EXT_CLK, 8'h5a);
        wr(OFF_PORT_CFG, 8'h3c);
        rd(OFF_PORT_CFG, 8'h3c);
        `CHK(global_port_cfg, 8'h3c)
        legacy_pinout_sel <= 1'b1;
        wr(OFF_EXT_CLK, 8'hff);
        rd(OFF_EXT_CLK, 8'h5a);
        `CHK(ext_clock_mode, 8'h5a)
        legacy_pinout_sel <= 1'b0;
        wr(OFF_LOS_DET, 8'h0a);
        wr(OFF_LOS_REC, 8'h15);
        rd(OFF_LOS_REC, 8'h15);
        wr(12'h044, 8'ha5);
        tx_slot <= 4'h1;
        rd(12'h044, 8'h00);
        `CHK(tx_pattern, 8'ha5)
        wr(12'h030, 8'h00);
        rd(12'h030, 8'h00);
        `CHK(pslverr, 1'b0)
        wr(OFF_CMD, 8'h03);
        @(negedge pclk);
        `CHK({tx_soft_reset, rx_soft_reset}, 2'b11)
        @(negedge pclk);
        `CHK({tx_soft_reset, rx_soft_reset}, 2'b00)
        rd(OFF_CMD, 8'h00);
        // every code on the digital line, then fallback on analog
        wr(OFF_MODE, 8'h7e);
        for (int c = 0; c < 4; c++) begin
            wr(OFF_CODE, 8'(c * 5));
            @(posedge pclk);
            @(negedge pclk);
            `CHK({tx_code, rx_code}, {e1lc_code_t'(c), e1lc_code_t'(c)})
        end
        wr(OFF_MODE, 8'h1e);
        wr(OFF_CODE, 8'h0e);
        @(posedge pclk);
        @(negedge pclk);
        `CHK({tx_code, rx_code}, {E1LC_AMI, E1LC_HDB3})
        cnt();
        `CHK(n, 2)
        `CHK(tx_line_bit, 1'b0)
        wr(OFF_MODE, 8'h16);
        cnt();
        `CHK(tx_line_bit, 1'b1)
        wr(OFF_MODE, 8'h06);
        cnt();
        `CHK(n, 0)
        @(posedge pclk);
        rx_slip_req <= 1'b1;
        rxb(1'b1);
        `CHK(rx_slip, 1'b0)
        wr(OFF_MODE, 8'h00);
        rxb(1'b1);
        `CHK(rx_slip, 1'b1)
        // zero run to the threshold, then ais and recovery
        repeat (175) rxb(1'b0);
        `CHK(los, 1'b0)
        rxb(1'b0);
        `CHK(los, 1'b1)
        // live los shows in the status word, nothing latched yet
        i_host.xfer(1'b0, OFF_STATUS, 8'h00, q);
        `CHK(q, 32'h0000_0001)
        rxb(1'b0);
        `CHK(rx_data_out, 1'b1)
        wr(OFF_MODE, 8'h02);
        rxb(1'b0);
        `CHK(rx_data_out, 1'b0)
        repeat (21) rxb(1'b1);
        `CHK(los, 1'b1)
        rxb(1'b1);
        `CHK(los, 1'b0)
        // one los event latched into bits 15:8
        wr(OFF_CNT_LATCH, 8'h00);
        i_host.xfer(1'b0, OFF_STATUS, 8'h00, q);
        `CHK(q, 32'h0000_0100)
        wr(OFF_MODE, 8'h01);
        repeat (2) @(negedge pclk);
        `CHK(settling, 1'b1)
        repeat (19) @(negedge pclk);
        `CHK(t1_mode_active, 1'b0)
        @(negedge pclk);
        `CHK(t1_mode_active, 1'b1)
        complete_run();
    end
endmodule
